//--- usbit_defines.svh
// Register offsets, field positions and reset values of the block
`ifndef USBIT_DEFINES_SVH
`define USBIT_DEFINES_SVH
`define USBIT_ADDR_W          12
`define USBIT_OFF_TX_FLAGS    12'h000
`define USBIT_OFF_RX_FLAGS    12'h004
`define USBIT_OFF_TX_EN       12'h008
`define USBIT_OFF_RX_EN       12'h00C
`define USBIT_OFF_COM_FLAGS   12'h010
`define USBIT_OFF_COM_EN      12'h014
`define USBIT_OFF_FRAME       12'h018
`define USBIT_OFF_SELECT      12'h01C
`define USBIT_OFF_TEST        12'h020
`define USBIT_OFF_POWER       12'h024
`define USBIT_OFF_CTRL        12'h028
`define USBIT_EP_W            5
`define USBIT_COM_W           8
`define USBIT_FRAME_W         11
`define USBIT_SEL_W           4
`define USBIT_TX_EN_RST       5'h1F
`define USBIT_RX_EN_RST       5'h1E
`define USBIT_RX_EP_MASK      5'h1E
`define USBIT_COM_EN_RST      8'h06
`define USBIT_COM_SUSPEND     0
`define USBIT_COM_RESUME      1
`define USBIT_COM_BUS_RESET   2
`define USBIT_COM_SOF         3
`define USBIT_COM_ATTACH      4
`define USBIT_COM_DISCONNECT_FLAG      5
`define USBIT_COM_SESS_REQ    6
`define USBIT_COM_VBUS_ERR    7
`define USBIT_TST_IDLE_NAK    0
`define USBIT_TST_J           1
`define USBIT_TST_K           2
`define USBIT_TST_PACKET      3
`define USBIT_TST_HS          4
`define USBIT_TST_FS          5
`define USBIT_TST_LOOPBACK    6
`define USBIT_TST_HOST        7
`define USBIT_TST_RW_MASK     8'hBF
`define USBIT_PWR_SUSP_OE     0
`define USBIT_PWR_SUSP_MODE   1
`define USBIT_PWR_RESUME      2
`define USBIT_CTRL_DIRECT     0
`endif

//--- usbit_pkg.sv
// Types shared by the interrupt, index and test-mode block
package usbit_pkg;
  typedef enum logic [1:0] {
    USBIT_SPD_NEGOTIATE,
    USBIT_SPD_HIGH,
    USBIT_SPD_FULL
  } usbit_speed_t;
endpackage

//--- usbit_flag_if.sv
// Carrier between the register file and one sticky flag bank
`timescale 1ns/10ps
`default_nettype none
interface usbit_flag_if #(parameter int W = 8);
  logic [W-1:0] set_evt;
  logic [W-1:0] clr_mask;
  logic [W-1:0] flags;
  modport src  (output set_evt, output clr_mask, input flags);
  modport bank (input set_evt, input clr_mask, output flags);
endinterface
`default_nettype wire

//--- usbit_flags.sv
// Sticky event flag bank, cleared by read, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module usbit_flags #(
  parameter int W = 8
) (
  input  wire logic pclk,
  input  wire logic presetn,
  usbit_flag_if.bank fi
);
  logic [W-1:0] next_flags;

  // Only bits seen by the read are cleared, so late events survive
  always_comb begin
    next_flags = (fi.flags & ~fi.clr_mask) | fi.set_evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fi.flags <= '0;
    end else begin
      fi.flags <= next_flags;
    end
  end
endmodule
`default_nettype wire

//--- usbit_top.sv
// Interrupt flags, frame capture, endpoint index and test-mode control
//
// Functional notes
// - Suspend output driven only when enabled
// - Suspend status set on entry, cleared by read/resume
// - Transmit flags: endpoint 0 plus tx 1-4
// - Receive flags: rx endpoints 1-4, bit0 zero
// - Transmit enables, five bits, reset to one
// - Receive enables bits 1-4, reset to one
// - Reading common flags clears active flags
// - Bus power error flag as A device
// - Session request flag as A device
// - Disconnect on session end, connect in host
// - Start-of-frame flag on each new frame
// - Bus reset, resume, suspend event flags
// - Common enables, reset/resume enabled at reset
// - Frame register holds last frame number
// - Endpoint select picks indexed register set
// - Forced host mode held for session
// - Speed overrides apply on bus reset
// - Loopback bit moves ep0 packet, self-clears
// - Test packet repeated while bit set
// - Continuous K or J while bit set
// - Idle NAK test: high speed, NAK INs
`timescale 1ns/10ps
`default_nettype none
`include "usbit_defines.svh"
module usbit_top #(
  parameter int ADDR_W = `USBIT_ADDR_W
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [`USBIT_EP_W-1:0]  ep_tx_evt,
  input  wire logic [`USBIT_EP_W-2:0]  ep_rx_evt,
  input  wire logic                    ev_suspend,
  input  wire logic                    ev_resume,
  input  wire logic                    ev_bus_reset,
  input  wire logic                    ev_sof,
  input  wire logic [`USBIT_FRAME_W-1:0] sof_frame_num,
  input  wire logic                    ev_attach,
  input  wire logic                    ev_session_end,
  input  wire logic                    ev_session_req,
  input  wire logic                    vbus_valid_pin,
  input  wire logic                    session_active,
  input  wire logic                    a_device,
  input  wire logic                    host_detected,
  output logic                         irq,
  output logic                         suspend_mode_output,
  output logic [`USBIT_SEL_W-1:0]      endpoint_select,
  output logic                         host_mode,
  output usbit_pkg::usbit_speed_t      speed_sel,
  output logic                         ep0_loopback,
  output logic                         test_packet_mode,
  output logic                         drive_k,
  output logic                         drive_j,
  output logic                         idle_nak_test_mode,
  output logic                         direct_int_access
);
  localparam int EW = `USBIT_EP_W;
  localparam int CW = `USBIT_COM_W;
  localparam int FW = `USBIT_FRAME_W;
  localparam int SW = `USBIT_SEL_W;

  ////////////////////////////////////////////////////////////////////
  // Register state
  logic [EW-1:0] tx_endpoint_int_enables;
  logic [EW-1:0] rx_endpoint_int_enables;
  logic [CW-1:0] common_bus_event_enables;
  logic [FW-1:0] last_frame_count;
  logic [7:0]    compliance_test_control;
  logic          suspend_output_enable;
  logic          suspend_mode;
  logic          resume_req;
  logic          forced_host;
  logic          vbus_meta;
  logic          vbus_sync;
  logic          vbus_prev;
  logic          rd_com;
  logic          rd_tx;
  logic          rd_rx;
  logic          setup_ph;
  logic          access_ph;
  logic          wr_en;
  logic [CW-1:0] com_set;
  logic [ADDR_W-1:0] word_addr;

  usbit_flag_if #(.W(EW)) tx_fi ();
  usbit_flag_if #(.W(EW)) rx_fi ();
  usbit_flag_if #(.W(CW)) com_fi ();

  ////////////////////////////////////////////////////////////////////
  // Address decode
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    case (a)
      `USBIT_OFF_TX_FLAGS,
      `USBIT_OFF_RX_FLAGS,
      `USBIT_OFF_TX_EN,
      `USBIT_OFF_RX_EN,
      `USBIT_OFF_COM_FLAGS,
      `USBIT_OFF_COM_EN,
      `USBIT_OFF_FRAME,
      `USBIT_OFF_SELECT,
      `USBIT_OFF_TEST,
      `USBIT_OFF_POWER,
      `USBIT_OFF_CTRL: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  assign word_addr = {paddr[ADDR_W-1:2], 2'b00};
  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  // Read data is staged in setup, so access never waits
  assign pready    = 1'b1;
  assign wr_en     = access_ph & pwrite;

  ////////////////////////////////////////////////////////////////////
  // APB read path
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h0000_0000;
    case (word_addr)
      `USBIT_OFF_TX_FLAGS: next_prdata[EW-1:0] = tx_fi.flags;
      `USBIT_OFF_RX_FLAGS: next_prdata[EW-1:0] =
        rx_fi.flags & `USBIT_RX_EP_MASK;
      `USBIT_OFF_TX_EN: next_prdata[EW-1:0] = tx_endpoint_int_enables;
      `USBIT_OFF_RX_EN: next_prdata[EW-1:0] = rx_endpoint_int_enables;
      `USBIT_OFF_COM_FLAGS: next_prdata[CW-1:0] = com_fi.flags;
      `USBIT_OFF_COM_EN: next_prdata[CW-1:0] = common_bus_event_enables;
      `USBIT_OFF_FRAME: next_prdata[FW-1:0] = last_frame_count;
      `USBIT_OFF_SELECT: next_prdata[SW-1:0] = endpoint_select;
      `USBIT_OFF_TEST: next_prdata[7:0] =
        compliance_test_control & `USBIT_TST_RW_MASK;
      `USBIT_OFF_POWER: begin
        next_prdata[`USBIT_PWR_SUSP_OE]   = suspend_output_enable;
        next_prdata[`USBIT_PWR_SUSP_MODE] = suspend_mode;
        next_prdata[`USBIT_PWR_RESUME]    = resume_req;
      end
      `USBIT_OFF_CTRL: next_prdata[`USBIT_CTRL_DIRECT] = direct_int_access;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= ~is_mapped(word_addr);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read-to-clear strobes, taken at the completing access edge
  assign rd_tx  = access_ph & ~pwrite & hit(word_addr, `USBIT_OFF_TX_FLAGS);
  assign rd_rx  = access_ph & ~pwrite & hit(word_addr, `USBIT_OFF_RX_FLAGS);
  assign rd_com = access_ph & ~pwrite & hit(word_addr, `USBIT_OFF_COM_FLAGS);

  // Clear only what the read showed; a newer event stays pending
  assign tx_fi.clr_mask  = rd_tx ? prdata[EW-1:0] : '0;
  assign rx_fi.clr_mask  = rd_rx ? prdata[EW-1:0] : '0;
  assign com_fi.clr_mask = rd_com ? prdata[CW-1:0] : '0;

  assign tx_fi.set_evt = ep_tx_evt;
  assign rx_fi.set_evt = {ep_rx_evt, 1'b0};
  assign com_fi.set_evt = com_set;

  usbit_flags #(.W(EW)) u_tx_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (tx_fi)
  );

  usbit_flags #(.W(EW)) u_rx_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (rx_fi)
  );

  usbit_flags #(.W(CW)) u_com_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (com_fi)
  );

  ////////////////////////////////////////////////////////////////////
  // Bus supply pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_meta <= 1'b0;
      vbus_sync <= 1'b0;
      vbus_prev <= 1'b0;
    end else begin
      vbus_meta <= vbus_valid_pin;
      vbus_sync <= vbus_meta;
      vbus_prev <= vbus_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Common event sources
  always_comb begin
    com_set = '0;
    com_set[`USBIT_COM_SUSPEND]   = ev_suspend;
    com_set[`USBIT_COM_RESUME]    = ev_resume & suspend_mode;
    com_set[`USBIT_COM_BUS_RESET] = ev_bus_reset;
    com_set[`USBIT_COM_SOF]       = ev_sof;
    com_set[`USBIT_COM_ATTACH]    = ev_attach & host_mode;
    com_set[`USBIT_COM_DISCONNECT_FLAG]    = ev_session_end;
    com_set[`USBIT_COM_SESS_REQ]  = ev_session_req & a_device;
    com_set[`USBIT_COM_VBUS_ERR]  =
      vbus_prev & ~vbus_sync & session_active & a_device;
  end

  ////////////////////////////////////////////////////////////////////
  // Enable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_endpoint_int_enables <= `USBIT_TX_EN_RST;
      rx_endpoint_int_enables <= `USBIT_RX_EN_RST;
      common_bus_event_enables <= `USBIT_COM_EN_RST;
    end else if (wr_en) begin
      if (hit(word_addr, `USBIT_OFF_TX_EN)) begin
        tx_endpoint_int_enables <= pwdata[EW-1:0];
      end
      if (hit(word_addr, `USBIT_OFF_RX_EN)) begin
        rx_endpoint_int_enables <=
          pwdata[EW-1:0] & `USBIT_RX_EP_MASK;
      end
      if (hit(word_addr, `USBIT_OFF_COM_EN)) begin
        common_bus_event_enables <= pwdata[CW-1:0];
      end
    end
  end

  // One request line for the whole block
  assign irq = |(tx_fi.flags & tx_endpoint_int_enables) |
               |(rx_fi.flags & rx_endpoint_int_enables) |
               |(com_fi.flags & common_bus_event_enables);

  ////////////////////////////////////////////////////////////////////
  // Frame number capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_frame_count <= '0;
    end else if (ev_sof) begin
      last_frame_count <= sof_frame_num;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Endpoint select and controller control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      endpoint_select <= '0;
    end else if (wr_en && hit(word_addr, `USBIT_OFF_SELECT)) begin
      endpoint_select <= pwdata[SW-1:0];
    end
  end

  // Wrappers live elsewhere; this bit only tells them to stand aside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_int_access <= 1'b0;
    end else if (wr_en && hit(word_addr, `USBIT_OFF_CTRL)) begin
      direct_int_access <= pwdata[`USBIT_CTRL_DIRECT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power control and suspend status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_output_enable <= 1'b0;
      resume_req            <= 1'b0;
    end else if (wr_en && hit(word_addr, `USBIT_OFF_POWER)) begin
      suspend_output_enable <= pwdata[`USBIT_PWR_SUSP_OE];
      resume_req            <= pwdata[`USBIT_PWR_RESUME];
    end
  end

  // Entry into suspend wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_mode <= 1'b0;
    end else if (ev_suspend) begin
      suspend_mode <= 1'b1;
    end else if (rd_com || (wr_en && hit(word_addr, `USBIT_OFF_POWER)
                 && pwdata[`USBIT_PWR_RESUME])) begin
      suspend_mode <= 1'b0;
    end
  end

  assign suspend_mode_output = suspend_output_enable & suspend_mode;

  ////////////////////////////////////////////////////////////////////
  // Test mode register
  logic next_loopback;

  assign next_loopback = wr_en & hit(word_addr, `USBIT_OFF_TEST) &
                         pwdata[`USBIT_TST_LOOPBACK];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compliance_test_control <= 8'h00;
    end else if (wr_en && hit(word_addr, `USBIT_OFF_TEST)) begin
      compliance_test_control <= pwdata[7:0] & `USBIT_TST_RW_MASK;
    end
  end

  // Write-only bit: a single pulse, never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep0_loopback <= 1'b0;
    end else begin
      ep0_loopback <= next_loopback;
    end
  end

  assign test_packet_mode =
    compliance_test_control[`USBIT_TST_PACKET];
  // K takes precedence if software sets both
  assign drive_k = compliance_test_control[`USBIT_TST_K];
  assign drive_j = compliance_test_control[`USBIT_TST_J] &
                   ~compliance_test_control[`USBIT_TST_K];
  assign idle_nak_test_mode =
    compliance_test_control[`USBIT_TST_IDLE_NAK];

  ////////////////////////////////////////////////////////////////////
  // Forced host mode, held until the session ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_host <= 1'b0;
    end else if (!session_active) begin
      forced_host <= 1'b0;
    end else if (compliance_test_control[`USBIT_TST_HOST]) begin
      forced_host <= 1'b1;
    end
  end

  assign host_mode = host_detected | forced_host;

  ////////////////////////////////////////////////////////////////////
  // Speed selection
  logic                    forced_host_prev;
  usbit_pkg::usbit_speed_t next_speed;

  always_comb begin
    if (compliance_test_control[`USBIT_TST_FS]) begin
      next_speed = usbit_pkg::USBIT_SPD_FULL;
    end else if (compliance_test_control[`USBIT_TST_HS] ||
                 idle_nak_test_mode) begin
      next_speed = usbit_pkg::USBIT_SPD_HIGH;
    end else begin
      next_speed = usbit_pkg::USBIT_SPD_NEGOTIATE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_host_prev <= 1'b0;
      speed_sel        <= usbit_pkg::USBIT_SPD_NEGOTIATE;
    end else begin
      forced_host_prev <= forced_host;
      if (ev_bus_reset || (forced_host && !forced_host_prev)) begin
        speed_sel <= next_speed;
      end else if (idle_nak_test_mode) begin
        speed_sel <= usbit_pkg::USBIT_SPD_HIGH;
      end
    end
  end
endmodule
`default_nettype wire

//--- usbit_assertions.sv
// Concurrent checks on the ports of the interrupt and test-mode block
`timescale 1ns/10ps
`default_nettype none
`include "usbit_defines.svh"
module usbit_assertions #(
  parameter int ADDR_W = `USBIT_ADDR_W
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [ADDR_W-1:0]       paddr,
  input wire logic [31:0]             pwdata,
  input wire logic [31:0]             prdata,
  input wire logic                    ev_suspend,
  input wire logic                    ev_bus_reset,
  input wire logic                    session_active,
  input wire logic                    host_detected,
  input wire logic                    irq,
  input wire logic                    suspend_mode_output,
  input wire logic [`USBIT_SEL_W-1:0] endpoint_select,
  input wire logic                    host_mode,
  input wire usbit_pkg::usbit_speed_t speed_sel,
  input wire logic                    ep0_loopback,
  input wire logic                    test_packet_mode,
  input wire logic                    drive_k,
  input wire logic                    drive_j,
  input wire logic                    idle_nak_test_mode
);
  logic       wr;
  logic       rd;
  logic       pwr_oe;
  logic [7:0] com_en;
  logic [7:0] tst;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  // Shadows of the writable bits that steer outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_oe <= 1'b0;
      com_en <= `USBIT_COM_EN_RST;
      tst    <= 8'h00;
    end else if (wr) begin
      if (paddr == `USBIT_OFF_POWER) pwr_oe <= pwdata[0];
      if (paddr == `USBIT_OFF_COM_EN) com_en <= pwdata[7:0];
      if (paddr == `USBIT_OFF_TEST) tst <= pwdata[7:0] & `USBIT_TST_RW_MASK;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  susp_gate_a: assert property (!pwr_oe |-> !suspend_mode_output)
    else $error("suspend output while off");
  susp_entry_a: assert property (ev_suspend && pwr_oe && !wr
    |=> suspend_mode_output) else $error("suspend entry not shown");
  irq_enable_a: assert property (ev_bus_reset && com_en[2] |=> irq)
    else $error("no bus reset interrupt");
  tx_rsvd_a: assert property (rd && paddr == `USBIT_OFF_TX_FLAGS
    |-> prdata[31:5] == 27'h0) else $error("tx reserved set");
  rx_rsvd_a: assert property (rd && paddr == `USBIT_OFF_RX_FLAGS
    |-> prdata[31:5] == 27'h0 && !prdata[0]) else $error("rx reserved set");
  frame_rsvd_a: assert property (rd && paddr == `USBIT_OFF_FRAME
    |-> prdata[31:11] == 21'h0) else $error("frame upper bits set");
  sel_load_a: assert property (wr && paddr == `USBIT_OFF_SELECT
    |=> endpoint_select == $past(pwdata[3:0])) else $error("select not loaded");
  sel_hold_a: assert property (!(wr && paddr == `USBIT_OFF_SELECT)
    |=> $stable(endpoint_select)) else $error("select changed unasked");
  test_outs_a: assert property (test_packet_mode == tst[3]
    && drive_k == tst[2] && drive_j == (tst[1] && !tst[2])
    && idle_nak_test_mode == tst[0]) else $error("test outputs differ");
  lb_pulse_a: assert property (wr && paddr == `USBIT_OFF_TEST && pwdata[6]
    |-> ##[1:2] (ep0_loopback ##1 !ep0_loopback)) else $error("loopback pulse");
  host_end_a: assert property (!session_active ##1
    (!session_active && !host_detected) |-> !host_mode)
    else $error("host mode kept");
  speed_fs_a: assert property (ev_bus_reset && tst[5] && !tst[0]
    |=> speed_sel == usbit_pkg::USBIT_SPD_FULL) else $error("no full speed");
endmodule
bind usbit_top usbit_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .ev_suspend, .ev_bus_reset, .session_active, .host_detected, .irq,
  .suspend_mode_output, .endpoint_select, .host_mode, .speed_sel,
  .ep0_loopback, .test_packet_mode, .drive_k, .drive_j, .idle_nak_test_mode);
`default_nettype wire

//--- usbit_usb_far_model.sv
// Behavioural far side of the bus: event pulses and bus levels
`timescale 1ns/10ps
`default_nettype none
module usbit_usb_far_model (
  input  wire logic   clk,
  output logic [4:0]  ep_tx_evt,
  output logic [3:0]  ep_rx_evt,
  output logic [6:0]  ev,
  output logic [10:0] sof_frame_num,
  output logic        vbus_valid_pin,
  output logic        session_active,
  output logic        a_device,
  output logic        host_detected
);
  initial begin
    ep_tx_evt = '0;
    ep_rx_evt = '0;
    ev = '0;
    sof_frame_num = '0;
    vbus_valid_pin = 1'b1;
    session_active = 1'b0;
    a_device = 1'b0;
    host_detected = 1'b0;
  end
  // One-cycle event pulses
  task automatic fire(input logic [6:0] c, input logic [4:0] t,
                      input logic [3:0] r, input logic [10:0] f);
    @(posedge clk);
    ev            <= c;
    ep_tx_evt     <= t;
    ep_rx_evt     <= r;
    sof_frame_num <= f;
    @(posedge clk);
    ev            <= '0;
    ep_tx_evt     <= '0;
    ep_rx_evt     <= '0;
    sof_frame_num <= ~f;
    @(negedge clk);
  endtask
  task automatic lv(input logic v, input logic s, input logic a,
                    input logic h);
    @(posedge clk);
    vbus_valid_pin <= v;
    session_active <= s;
    a_device       <= a;
    host_detected  <= h;
  endtask
endmodule
`default_nettype wire

//--- tb_usbit_top.sv
// Self-checking bench for the interrupt, index and test-mode block
`timescale 1ns/10ps
`default_nettype none
`include "usbit_defines.svh"
module tb_usbit_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  ep_tx_evt;
  logic [3:0]  ep_rx_evt;
  logic [6:0]  ev;
  logic [10:0] sof_frame_num;
  logic        vbus_valid_pin;
  logic        session_active;
  logic        a_device;
  logic        host_detected;
  logic        irq;
  logic        susp_out;
  logic [3:0]  endpoint_select;
  logic        host_mode;
  logic [1:0]  speed_sel;
  logic        drive_k;
  logic        drive_j;
  logic        tst_pkt;
  logic        idle_nak;
  logic        direct_int_access;
  logic [31:0] rdata;
  logic        rerr;
  int          mismatches;
  int          tests_run;
  usbit_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ep_tx_evt, .ep_rx_evt,
    .ev_suspend(ev[0]), .ev_resume(ev[1]), .ev_bus_reset(ev[2]),
    .ev_sof(ev[3]), .sof_frame_num, .ev_attach(ev[4]),
    .ev_session_end(ev[5]), .ev_session_req(ev[6]), .vbus_valid_pin,
    .session_active, .a_device, .host_detected, .irq,
    .suspend_mode_output(susp_out), .endpoint_select, .host_mode, .speed_sel,
    .ep0_loopback(), .test_packet_mode(tst_pkt), .drive_k, .drive_j,
    .idle_nak_test_mode(idle_nak), .direct_int_access);
  usbit_usb_far_model far (.clk(pclk), .ep_tx_evt, .ep_rx_evt, .ev,
    .sof_frame_num, .vbus_valid_pin, .session_active, .a_device,
    .host_detected);
  always #50 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg(rdata, exp);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #2_000_000;
    mismatches++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(`USBIT_OFF_TX_EN, 32'h0000_001F);
    rd(`USBIT_OFF_RX_EN, 32'h0000_001E);
    rd(`USBIT_OFF_COM_EN, 32'h0000_0006);
    rd(`USBIT_OFF_SELECT, 32'h0000_0000);
    rd(`USBIT_OFF_FRAME, 32'h0000_0000);
    $display("test resets done");
    wr(`USBIT_OFF_TX_EN, 32'hFFFF_FFFF);
    rd(`USBIT_OFF_TX_EN, 32'h0000_001F);
    wr(`USBIT_OFF_RX_EN, 32'hFFFF_FFFF);
    rd(`USBIT_OFF_RX_EN, 32'h0000_001E);
    far.fire(7'h00, 5'h1F, 4'hF, 11'h000);
    pin(irq, 1'b1);
    rd(`USBIT_OFF_TX_FLAGS, 32'h0000_001F);
    rd(`USBIT_OFF_RX_FLAGS, 32'h0000_001E);
    rd(`USBIT_OFF_TX_FLAGS, 32'h0000_0000);
    rd(`USBIT_OFF_RX_FLAGS, 32'h0000_0000);
    pin(irq, 1'b0);
    wr(`USBIT_OFF_TX_EN, 32'h0000_0000);
    far.fire(7'h00, 5'h01, 4'h0, 11'h000);
    pin(irq, 1'b0);
    rd(`USBIT_OFF_TX_FLAGS, 32'h0000_0001);
    $display("test ep flags done");
    wr(`USBIT_OFF_CTRL, 32'h0000_0001);
    pin(direct_int_access, 1'b1);
    wr(`USBIT_OFF_COM_EN, 32'h0000_00FF);
    wr(`USBIT_OFF_POWER, 32'h0000_0001);
    far.lv(1'b1, 1'b1, 1'b1, 1'b1);
    far.fire(7'h01, 5'h00, 4'h0, 11'h000);
    pin(susp_out, 1'b1);
    far.fire(7'h7E, 5'h00, 4'h0, 11'h7FF);
    far.lv(1'b0, 1'b1, 1'b1, 1'b1);
    repeat (6) @(negedge pclk);
    pin(irq, 1'b1);
    rd(`USBIT_OFF_COM_FLAGS, 32'h0000_00FF);
    pin(susp_out, 1'b0);
    rd(`USBIT_OFF_COM_FLAGS, 32'h0000_0000);
    wr(`USBIT_OFF_FRAME, 32'hFFFF_0000);
    rd(`USBIT_OFF_FRAME, 32'h0000_07FF);
    wr(`USBIT_OFF_POWER, 32'h0000_0000);
    far.lv(1'b1, 1'b1, 1'b0, 1'b0);
    far.fire(7'h53, 5'h00, 4'h0, 11'h000);
    pin(susp_out, 1'b0);
    rd(`USBIT_OFF_COM_FLAGS, 32'h0000_0001);
    wr(`USBIT_OFF_COM_EN, 32'h0000_0000);
    far.fire(7'h08, 5'h00, 4'h0, 11'h123);
    pin(irq, 1'b0);
    rd(`USBIT_OFF_COM_FLAGS, 32'h0000_0008);
    rd(`USBIT_OFF_FRAME, 32'h0000_0123);
    $display("test common flags done");
    wr(`USBIT_OFF_SELECT, 32'hFFFF_FFFF);
    rd(`USBIT_OFF_SELECT, 32'h0000_000F);
    chk_reg({28'h0, endpoint_select}, 32'h0000_000F);
    for (int i = 0; i < 8; i++) begin
      wr(`USBIT_OFF_TEST, 32'h1 << i);
      rd(`USBIT_OFF_TEST, (32'h1 << i) & 32'h0000_00BF);
      pin(drive_k, i == 2);
      pin(drive_j, i == 1);
      pin(tst_pkt, i == 3);
      pin(idle_nak, i == 0);
    end
    wr(`USBIT_OFF_TEST, 32'h0000_0020);
    far.fire(7'h04, 5'h00, 4'h0, 11'h000);
    chk_reg({30'h0, speed_sel}, {30'h0, usbit_pkg::USBIT_SPD_FULL});
    wr(`USBIT_OFF_TEST, 32'h0000_0010);
    far.fire(7'h04, 5'h00, 4'h0, 11'h000);
    chk_reg({30'h0, speed_sel}, {30'h0, usbit_pkg::USBIT_SPD_HIGH});
    wr(`USBIT_OFF_TEST, 32'h0000_0080);
    repeat (2) @(negedge pclk);
    pin(host_mode, 1'b1);
    far.lv(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (2) @(negedge pclk);
    pin(host_mode, 1'b0);
    far.lv(1'b1, 1'b1, 1'b1, 1'b0);
    repeat (2) @(negedge pclk);
    pin(host_mode, 1'b1);
    $display("test modes done");
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk_reg(rdata, 32'h0000_0000);
    pin(rerr, 1'b1);
    $display("test unmapped done");
    end_sim();
  end
endmodule
`default_nettype wire
